/* sim/front_panel_status_control_tb.sv */
// self-checking bench for the front panel status and button logic
`timescale 1ns/1ps
module front_panel_status_control_tb;
	localparam logic [1:0] GRN = fp_pkg::LED_GREEN;
	localparam logic [1:0] YEL = fp_pkg::LED_YELLOW;
	localparam logic [1:0] RED = fp_pkg::LED_RED;
	logic clock, rstn, buttonPin, knobStep, awvalid, wvalid, bready, arvalid, rready;
	logic awready, wready, bvalid, arready, rvalid;
	logic backlightOn, selInput, autoSelect, dynAddrEnable, restartReq;
	logic [7:0] awaddr, araddr;
	logic [31:0] wdata, rdata, rd;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp, rr, br;
	logic [9:0] front;
	fp_pkg::led_t ledPower, ledLink, ledEnc, ledIn1, ledIn2, ledSignal, ledConv, ledLaser;
	fp_pkg::conv_t convMode;
	int nFail = 0;
	int checksDone = 0;

	assign front = {ledLink, ledEnc, ledIn1, ledIn2, ledLaser};

	// short counts keep the run brief; hold must outlast the debounce
	front_panel_status_control #(.TICK_CYCLES(10), .HOLD_MS(60), .WINDOW_MS(200),
		.DARK_MS(50)) u_dut (
		.clock, .rstn, .buttonPin, .knobStep,
		.ledPower, .ledLink, .ledEnc, .ledIn1, .ledIn2, .ledSignal, .ledConv, .ledLaser,
		.backlightOn, .selInput, .autoSelect, .convMode, .dynAddrEnable, .restartReq,
		.awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid,
		.bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready);

	panel_operator u_op (.clock, .buttonPin, .knobStep);

	initial begin
		clock = 1'b0;
		forever #2 clock = ~clock;
	end

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		checksDone++;
		if (got !== exp) begin
			nFail++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic conclude();
		$display("checks %0d mismatches %0d", checksDone, nFail);
		if (nFail == 0 && checksDone > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	task automatic axw(input logic [7:0] a, input logic [31:0] d);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge clock);
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
		end while (bvalid !== 1'b1);
		br = bresp;
		bready <= 1'b0;
		repeat (3) @(posedge clock);
	endtask

	task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge clock);
			if (arvalid && arready) arvalid <= 1'b0;
		end while (rvalid !== 1'b1);
		d = rdata;
		r = rresp;
		rready <= 1'b0;
		@(posedge clock);
	endtask

	initial begin
		rstn = 1'b0;
		awvalid = 1'b0;
		wvalid = 1'b0;
		bready = 1'b0;
		arvalid = 1'b0;
		rready = 1'b0;
		awaddr = 8'h00;
		araddr = 8'h00;
		wdata = 32'h0;
		wstrb = 4'hf;
		repeat (10) @(posedge clock);
		rstn <= 1'b1;
		@(posedge clock);
		chk("dyn", 0, dynAddrEnable);
		axw(fp_pkg::ADDR_CTRL, 32'h1c);
		axw(fp_pkg::ADDR_COND, 32'h335);
		chk("bresp", fp_pkg::RESP_OKAY, br);
		chk("power", GRN, ledPower);
		chk("leds", {GRN, GRN, GRN, YEL, RED}, front);
		axw(fp_pkg::ADDR_COND, 32'h200);
		chk("leds", 0, front);
		axw(fp_pkg::ADDR_CTRL, 32'h14);
		axw(fp_pkg::ADDR_COND, 32'h335);
		u_op.push(30, 30);
		chk("sel", 1, selInput);
		chk("auto", 0, autoSelect);
		chk("leds", {GRN, GRN, YEL, GRN, RED}, front);
		axw(fp_pkg::ADDR_CTRL, 32'h06);
		u_op.down(25);
		chk("locked", {GRN, GRN, GRN, GRN, RED}, front);
		u_op.up(1600);
		chk("sel", 1, selInput);
		axw(fp_pkg::ADDR_CTRL, 32'h00);
		// low byte only: upper condition bits must survive
		wstrb <= 4'h1;
		axw(fp_pkg::ADDR_COND, 32'h40);
		wstrb <= 4'hf;
		chk("signal", GRN, ledSignal);
		axr(fp_pkg::ADDR_COND, rd, rr);
		chk("cond", 32'h340, rd);
		for (int i = 1; i < 4; i++) begin
			u_op.push(30, 30);
			chk("conv", i % 3, convMode);
			chk("convLed", i == 1 ? GRN : i == 2 ? YEL : 0, ledConv);
		end
		axw(fp_pkg::ADDR_COND, 32'h335);
		axw(fp_pkg::ADDR_CTRL, 32'h04);
		u_op.push(90, 25);
		u_op.push(25, 300);
		chk("dyn", 0, dynAddrEnable);
		chk("leds", {GRN, GRN, YEL, GRN, RED}, front);
		axw(fp_pkg::ADDR_CTRL, 32'h05);
		u_op.up(30);
		chk("leds", {GRN, GRN, YEL, GRN, RED}, front);
		u_op.up(40);
		chk("leds", 0, front);
		chk("light", 0, backlightOn);
		u_op.push(30, 10);
		chk("light", 1, backlightOn);
		chk("sel", 1, selInput);
		u_op.up(60);
		chk("light", 0, backlightOn);
		u_op.turn(5);
		chk("light", 1, backlightOn);
		chk("sel", 1, selInput);
		axw(fp_pkg::ADDR_CTRL, 32'h04);
		u_op.push(90, 25);
		repeat (3) u_op.push(25, 25);
		chk("dyn", 1, dynAddrEnable);
		chk("leds", 0, front);
		u_op.up(150);
		chk("restart", 1, restartReq);
		axr(fp_pkg::ADDR_STATE, rd, rr);
		chk("stateDyn", 1, rd[fp_pkg::STATE_DYN]);
		axw(8'h0c, 32'h1);
		chk("bresp", fp_pkg::RESP_SLVERR, br);
		axr(8'h0c, rd, rr);
		chk("resp", fp_pkg::RESP_SLVERR, rr);
		conclude();
	end

	// hang guard, well past the expected run length
	initial begin
		repeat (90000) @(posedge clock);
		nFail++;
		conclude();
	end
endmodule

/* sim/panel_operator.sv */
// human operator model pressing the panel button
`timescale 1ns/1ps
module panel_operator #(
	parameter int TICK = 10
) (
	// clock
	input wire logic clock,
	// panel pins, idle released
	output logic buttonPin,
	output logic knobStep
);
	initial begin
		buttonPin = 1'b0;
		knobStep = 1'b0;
	end
	task automatic down(input int ms);
		buttonPin <= 1'b1;
		repeat (ms * TICK) @(posedge clock);
	endtask
	task automatic up(input int ms);
		buttonPin <= 1'b0;
		repeat (ms * TICK) @(posedge clock);
	endtask
	// one knob movement, then a pause
	task automatic turn(input int ms);
		knobStep <= ~knobStep;
		repeat (ms * TICK) @(posedge clock);
	endtask
	task automatic push(input int dMs, input int uMs);
		down(dMs);
		up(uMs);
	endtask
endmodule

/* verilog/button_filter.sv */
// synchroniser and debouncer for the panel push button
`timescale 1ns/1ps
module button_filter #(
	parameter int DEBOUNCE_MS = fp_pkg::DEBOUNCE_MS
) (
	// clock and reset
	input wire logic clock,
	input wire logic rstn,
	// raw pin, high while pressed
	input wire logic buttonPin,
	// filtered events
	panel_if.filter pif
);
	fp_pkg::filt_st_t st_q;
	fp_pkg::filt_st_t st_d;

	// ----------------------------------------
	// debounce
	// ----------------------------------------
	always_comb begin
		st_d = st_q;
		st_d.s1 = buttonPin;
		st_d.s2 = st_q.s1;
		st_d.pEdge = 1'b0;
		st_d.rEdge = 1'b0;
		if (st_q.s2 == st_q.level) begin
			st_d.cnt = '0;
		end else if (pif.msTick) begin
			if (st_q.cnt == 8'(DEBOUNCE_MS - 1)) begin
				st_d.cnt = '0;
				st_d.level = st_q.s2;
				st_d.pEdge = st_q.s2;
				st_d.rEdge = ~st_q.s2;
			end else begin
				st_d.cnt = st_q.cnt + 8'h1;
			end
		end
	end

	always_ff @(posedge clock) begin
		if (!rstn) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	assign pif.pressEdge = st_q.pEdge;
	assign pif.releaseEdge = st_q.rEdge;
endmodule

/* verilog/fp_pkg.sv */
// shared constants and state types for the front panel status and button logic
package fp_pkg;

	// ----------------------------------------
	// timing
	// ----------------------------------------
	localparam int CLK_PERIOD_PS = 4000;
	localparam int TICK_PERIOD_PS = 1_000_000_000;
	localparam int TICK_CYCLES = TICK_PERIOD_PS / CLK_PERIOD_PS;
	localparam int HOLD_MS = 5000;
	localparam int WINDOW_MS = 1500;
	localparam int DARK_MS = 60000;
	localparam int DEBOUNCE_MS = 20;
	localparam int BLINK_HALF_MS = 250;
	localparam int LOCK_BLINKS = 3;
	localparam int RESTART_MS = 100;

	// ----------------------------------------
	// register map
	// ----------------------------------------
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_COND = 8'h04;
	localparam logic [7:0] ADDR_STATE = 8'h08;
	localparam int CTRL_DARK = 0;
	localparam int CTRL_LOCK = 1;
	localparam int CTRL_TX = 2;
	localparam int CTRL_OOS = 3;
	localparam int CTRL_AUTO = 4;
	localparam int COND_LINK = 0;
	localparam int COND_LINKERR = 1;
	localparam int COND_ENC = 2;
	localparam int COND_ENCERR = 3;
	localparam int COND_IN1 = 4;
	localparam int COND_IN2 = 5;
	localparam int COND_RXVID = 6;
	localparam int COND_RXERR = 7;
	localparam int COND_LASER = 8;
	localparam int COND_READY = 9;
	localparam int STATE_SEL = 0;
	localparam int STATE_CONV = 1;
	localparam int STATE_DYN = 3;
	localparam int STATE_DARK = 4;
	localparam int STATE_BTN = 5;
	localparam logic [4:0] CTRL_RST = 5'h00;
	localparam logic [9:0] COND_RST = 10'h000;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// ----------------------------------------
	// types
	// ----------------------------------------
	typedef enum logic [1:0] {LED_OFF, LED_GREEN, LED_YELLOW, LED_RED} led_t;
	typedef enum logic [1:0] {CONV_PASS, CONV_SPLIT, CONV_DOWN} conv_t;
	typedef enum logic [2:0] {B_IDLE, B_HELD, B_ARMED, B_SEQ, B_LOCK, B_DONE} bstate_t;

	typedef struct packed {
		logic [17:0] cnt;
		logic tick;
		logic [7:0] bcnt;
		logic blink;
	} tick_st_t;

	typedef struct packed {
		logic s1;
		logic s2;
		logic level;
		logic [7:0] cnt;
		logic pEdge;
		logic rEdge;
	} filt_st_t;

	typedef struct packed {
		logic [4:0] ctrl;
		logic [9:0] cond;
		logic sel;
		conv_t conv;
		logic dyn;
		logic dark;
		logic [15:0] darkCnt;
		bstate_t bst;
		logic [15:0] msCnt;
		logic [1:0] presses;
		logic [2:0] lockHalf;
		logic restart;
		logic k1;
		logic k2;
		logic k3;
		led_t lPower;
		led_t lLink;
		led_t lEnc;
		led_t lIn1;
		led_t lIn2;
		led_t lSignal;
		led_t lConv;
		led_t lLaser;
		logic awHave;
		logic [7:0] awAddr;
		logic wHave;
		logic [31:0] wData;
		logic [3:0] wStrb;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} st_t;

endpackage

/* verilog/front_panel_status_control.sv */
// front panel LED status and button sequence logic with AXI4-Lite registers
//
// Functional notes
// - dark setting active keeps every LED unlit once its wait has run out, functions keep running
// - power LED blinks green when ready; steady green on transmitter out of service
// - link LED green when connected, off when not, yellow blink on error
// - encryption LED green when encrypted, off when not, yellow blink on error
// - input LEDs: green, green blink, yellow or off per selection and video
// - rear laser LED steady red while radiating, off otherwise
// - receiver signal LED green with video, off without, yellow blink on error
// - locked panel: press blinks LEDs green three times, no button function
// - short select press toggles between first and second input
// - button never enables autoselect; choosing an input clears it
// - hold five seconds, LEDs blink, then three presses within 1.5 seconds
// - valid sequence darkens LEDs, enables dynamic addressing, then restarts
// - dynamic addressing starts disabled after reset
// - dark setting waits sixty seconds before LEDs and backlight go off
// - first touch in dark only wakes, no normal function
// - receiver button steps pass, split, downsample conversion modes
`timescale 1ns/1ps
module front_panel_status_control #(
	parameter int TICK_CYCLES = fp_pkg::TICK_CYCLES,
	parameter int HOLD_MS = fp_pkg::HOLD_MS,
	parameter int WINDOW_MS = fp_pkg::WINDOW_MS,
	parameter int DARK_MS = fp_pkg::DARK_MS
) (
	// clock and reset
	input wire logic clock,
	input wire logic rstn,
	// panel pins
	input wire logic buttonPin,
	input wire logic knobStep,
	// indicators
	output fp_pkg::led_t ledPower,
	output fp_pkg::led_t ledLink,
	output fp_pkg::led_t ledEnc,
	output fp_pkg::led_t ledIn1,
	output fp_pkg::led_t ledIn2,
	output fp_pkg::led_t ledSignal,
	output fp_pkg::led_t ledConv,
	output fp_pkg::led_t ledLaser,
	output logic backlightOn,
	// settings towards the unit
	output logic selInput,
	output logic autoSelect,
	output fp_pkg::conv_t convMode,
	output logic dynAddrEnable,
	output logic restartReq,
	// axi4-lite slave
	input wire logic [7:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [7:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready
);
	fp_pkg::st_t st_q;
	fp_pkg::st_t st_d;
	panel_if pif();
	logic isTx;
	logic knobEv;
	logic normalView;
	logic shortPress;

	// ----------------------------------------
	// timebase and button
	// ----------------------------------------
	tick_gen #(.TICK_CYCLES(TICK_CYCLES)) uTick (
		.clock(clock),
		.rstn(rstn),
		.pif(pif.timebase)
	);

	button_filter #(.DEBOUNCE_MS(fp_pkg::DEBOUNCE_MS)) uButton (
		.clock(clock),
		.rstn(rstn),
		.buttonPin(buttonPin),
		.pif(pif.filter)
	);

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	function automatic logic [31:0] mergeStrb(logic [31:0] old, logic [31:0] nw,
		logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				r[i*8 +: 8] = nw[i*8 +: 8];
			end
		end
		return r;
	endfunction

	function automatic fp_pkg::led_t blinkLed(logic phase, fp_pkg::led_t c);
		return phase ? c : fp_pkg::LED_OFF;
	endfunction

	function automatic fp_pkg::led_t triLed(logic err, logic on, logic phase);
		if (err) begin
			return phase ? fp_pkg::LED_YELLOW : fp_pkg::LED_OFF;
		end
		return on ? fp_pkg::LED_GREEN : fp_pkg::LED_OFF;
	endfunction

	function automatic fp_pkg::led_t inLed(logic chosen, logic valid, logic phase);
		if (chosen) begin
			return valid ? fp_pkg::LED_GREEN : blinkLed(phase, fp_pkg::LED_GREEN);
		end
		return valid ? fp_pkg::LED_YELLOW : fp_pkg::LED_OFF;
	endfunction

	function automatic logic [31:0] stateWord(fp_pkg::st_t s);
		logic [31:0] r;
		r = '0;
		r[fp_pkg::STATE_SEL] = s.sel;
		r[fp_pkg::STATE_CONV +: 2] = s.conv;
		r[fp_pkg::STATE_DYN] = s.dyn;
		r[fp_pkg::STATE_DARK] = s.dark;
		r[fp_pkg::STATE_BTN +: 3] = s.bst;
		return r;
	endfunction

	assign isTx = st_q.ctrl[fp_pkg::CTRL_TX];
	assign normalView = !st_q.dark && st_q.bst != fp_pkg::B_DONE;
	assign shortPress = st_q.bst == fp_pkg::B_HELD && pif.releaseEdge;

	// ----------------------------------------
	// next state
	// ----------------------------------------
	always_comb begin
		logic [31:0] w;
		logic c;
		fp_pkg::led_t all;
		st_d = st_q;
		w = '0;
		c = 1'b0;
		all = fp_pkg::LED_OFF;
		// knob pin: k1 feeds k2, k2 feeds k3; the event is k2 xor k3
		st_d.k1 = knobStep;
		st_d.k2 = st_q.k1;
		st_d.k3 = st_q.k2;
		knobEv = st_q.k2 ^ st_q.k3;

		// bus write, both channels held until the pair is complete
		if (awvalid && awready) begin
			st_d.awHave = 1'b1;
			st_d.awAddr = awaddr;
		end
		if (wvalid && wready) begin
			st_d.wHave = 1'b1;
			st_d.wData = wdata;
			st_d.wStrb = wstrb;
		end
		if (st_q.bvalid && bready) begin
			st_d.bvalid = 1'b0;
		end
		if (st_q.awHave && st_q.wHave && !st_q.bvalid) begin
			st_d.awHave = 1'b0;
			st_d.wHave = 1'b0;
			st_d.bvalid = 1'b1;
			st_d.bresp = fp_pkg::RESP_OKAY;
			unique case (st_q.awAddr)
				fp_pkg::ADDR_CTRL: begin
					w = mergeStrb(32'(st_q.ctrl), st_q.wData, st_q.wStrb);
					st_d.ctrl = w[4:0];
				end
				fp_pkg::ADDR_COND: begin
					w = mergeStrb(32'(st_q.cond), st_q.wData, st_q.wStrb);
					st_d.cond = w[9:0];
				end
				fp_pkg::ADDR_STATE: begin
					w = mergeStrb(stateWord(st_q), st_q.wData, st_q.wStrb);
					st_d.sel = w[fp_pkg::STATE_SEL];
					st_d.dyn = w[fp_pkg::STATE_DYN];
					// code 3 is not a mode; keep the old one
					if (w[fp_pkg::STATE_CONV +: 2] != 2'h3) begin
						st_d.conv = fp_pkg::conv_t'(w[fp_pkg::STATE_CONV +: 2]);
					end
				end
				default: st_d.bresp = fp_pkg::RESP_SLVERR;
			endcase
		end

		// bus read
		if (st_q.rvalid && rready) begin
			st_d.rvalid = 1'b0;
		end
		if (arvalid && arready) begin
			st_d.rvalid = 1'b1;
			st_d.rresp = fp_pkg::RESP_OKAY;
			unique case (araddr)
				fp_pkg::ADDR_CTRL: st_d.rdata = 32'(st_q.ctrl);
				fp_pkg::ADDR_COND: st_d.rdata = 32'(st_q.cond);
				fp_pkg::ADDR_STATE: st_d.rdata = stateWord(st_q);
				default: begin
					st_d.rdata = '0;
					st_d.rresp = fp_pkg::RESP_SLVERR;
				end
			endcase
		end

		if (!st_q.ctrl[fp_pkg::CTRL_DARK]) begin
			st_d.dark = 1'b0;
			st_d.darkCnt = '0;
		end else if (pif.pressEdge || knobEv) begin
			st_d.dark = 1'b0;
			st_d.darkCnt = '0;
		end else if (pif.msTick && !st_q.dark) begin
			if (st_q.darkCnt == 16'(DARK_MS - 1)) begin
				st_d.dark = 1'b1;
			end else begin
				st_d.darkCnt = st_q.darkCnt + 16'h1;
			end
		end

		// button sequencer, counts in ms ticks
		unique case (st_q.bst)
			fp_pkg::B_IDLE: begin
				st_d.msCnt = '0;
				st_d.presses = '0;
				st_d.lockHalf = '0;
				if (pif.pressEdge && !st_q.dark) begin
					st_d.bst = st_q.ctrl[fp_pkg::CTRL_LOCK] ? fp_pkg::B_LOCK : fp_pkg::B_HELD;
				end
			end
			fp_pkg::B_HELD: begin
				if (pif.releaseEdge) begin
					st_d.bst = fp_pkg::B_IDLE;
					if (isTx) begin
						st_d.sel = ~st_q.sel;
						st_d.ctrl[fp_pkg::CTRL_AUTO] = 1'b0;
					end else begin
						unique case (st_q.conv)
							fp_pkg::CONV_PASS: st_d.conv = fp_pkg::CONV_SPLIT;
							fp_pkg::CONV_SPLIT: st_d.conv = fp_pkg::CONV_DOWN;
							default: st_d.conv = fp_pkg::CONV_PASS;
						endcase
					end
				end else if (pif.msTick) begin
					if (st_q.msCnt == 16'(HOLD_MS - 1)) begin
						st_d.bst = fp_pkg::B_ARMED;
						st_d.msCnt = '0;
					end else begin
						st_d.msCnt = st_q.msCnt + 16'h1;
					end
				end
			end
			fp_pkg::B_ARMED: begin
				if (pif.releaseEdge) begin
					st_d.bst = fp_pkg::B_SEQ;
					st_d.msCnt = '0;
				end
			end
			fp_pkg::B_SEQ: begin
				if (pif.pressEdge) begin
					if (st_q.presses == 2'h2) begin
						st_d.bst = fp_pkg::B_DONE;
						st_d.msCnt = '0;
					end else begin
						st_d.presses = st_q.presses + 2'h1;
					end
				end else if (pif.msTick) begin
					if (st_q.msCnt == 16'(WINDOW_MS - 1)) begin
						st_d.bst = fp_pkg::B_IDLE;
					end else begin
						st_d.msCnt = st_q.msCnt + 16'h1;
					end
				end
			end
			fp_pkg::B_LOCK: begin
				if (pif.msTick) begin
					if (st_q.msCnt == 16'(fp_pkg::BLINK_HALF_MS - 1)) begin
						st_d.msCnt = '0;
						if (st_q.lockHalf == 3'(2 * fp_pkg::LOCK_BLINKS - 1)) begin
							st_d.bst = fp_pkg::B_IDLE;
						end else begin
							st_d.lockHalf = st_q.lockHalf + 3'h1;
						end
					end else begin
						st_d.msCnt = st_q.msCnt + 16'h1;
					end
				end
			end
			fp_pkg::B_DONE: begin
				// enable then restart; held until reset
				st_d.dyn = 1'b1;
				if (pif.msTick && !st_q.restart) begin
					if (st_q.msCnt == 16'(fp_pkg::RESTART_MS - 1)) begin
						st_d.restart = 1'b1;
					end else begin
						st_d.msCnt = st_q.msCnt + 16'h1;
					end
				end
			end
			default: st_d.bst = fp_pkg::B_IDLE;
		endcase

		if (st_q.ctrl[fp_pkg::CTRL_OOS]) begin
			st_d.lPower = isTx ? fp_pkg::LED_GREEN : fp_pkg::LED_OFF;
		end else begin
			st_d.lPower = st_q.cond[fp_pkg::COND_READY] ?
				blinkLed(pif.blink, fp_pkg::LED_GREEN) : fp_pkg::LED_OFF;
		end
		st_d.lLink = triLed(st_q.cond[fp_pkg::COND_LINKERR], st_q.cond[fp_pkg::COND_LINK],
			pif.blink);
		st_d.lEnc = triLed(st_q.cond[fp_pkg::COND_ENCERR], st_q.cond[fp_pkg::COND_ENC],
			pif.blink);
		st_d.lIn1 = isTx ? inLed(!st_q.sel, st_q.cond[fp_pkg::COND_IN1], pif.blink)
			: fp_pkg::LED_OFF;
		st_d.lIn2 = isTx ? inLed(st_q.sel, st_q.cond[fp_pkg::COND_IN2], pif.blink)
			: fp_pkg::LED_OFF;
		st_d.lSignal = isTx ? fp_pkg::LED_OFF : triLed(st_q.cond[fp_pkg::COND_RXERR],
			st_q.cond[fp_pkg::COND_RXVID], pif.blink);
		unique case (st_q.conv)
			fp_pkg::CONV_SPLIT: st_d.lConv = fp_pkg::LED_GREEN;
			fp_pkg::CONV_DOWN: st_d.lConv = fp_pkg::LED_YELLOW;
			default: st_d.lConv = fp_pkg::LED_OFF;
		endcase
		if (isTx) begin
			st_d.lConv = fp_pkg::LED_OFF;
		end
		// laser, kept out of the blink overlays for eye safety
		st_d.lLaser = st_q.cond[fp_pkg::COND_LASER] ? fp_pkg::LED_RED : fp_pkg::LED_OFF;

		// overlays on the front LEDs
		c = 1'b1;
		if (st_q.bst == fp_pkg::B_ARMED || st_q.bst == fp_pkg::B_SEQ) begin
			all = blinkLed(pif.blink, fp_pkg::LED_GREEN);
		end else if (st_q.bst == fp_pkg::B_LOCK) begin
			all = blinkLed(!st_q.lockHalf[0], fp_pkg::LED_GREEN);
		end else begin
			c = 1'b0;
		end
		if (!normalView) begin
			c = 1'b1;
			all = fp_pkg::LED_OFF;
			st_d.lLaser = fp_pkg::LED_OFF;
		end
		if (c) begin
			st_d.lPower = all;
			st_d.lLink = all;
			st_d.lEnc = all;
			st_d.lIn1 = isTx ? all : fp_pkg::LED_OFF;
			st_d.lIn2 = isTx ? all : fp_pkg::LED_OFF;
			st_d.lSignal = isTx ? fp_pkg::LED_OFF : all;
			st_d.lConv = isTx ? fp_pkg::LED_OFF : all;
		end
	end

	always_ff @(posedge clock) begin
		if (!rstn) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	assign awready = !st_q.awHave && !st_q.bvalid;
	assign wready = !st_q.wHave && !st_q.bvalid;
	assign arready = !st_q.rvalid;
	assign bvalid = st_q.bvalid;
	assign bresp = st_q.bresp;
	assign rvalid = st_q.rvalid;
	assign rdata = st_q.rdata;
	assign rresp = st_q.rresp;
	assign ledPower = st_q.lPower;
	assign ledLink = st_q.lLink;
	assign ledEnc = st_q.lEnc;
	assign ledIn1 = st_q.lIn1;
	assign ledIn2 = st_q.lIn2;
	assign ledSignal = st_q.lSignal;
	assign ledConv = st_q.lConv;
	assign ledLaser = st_q.lLaser;
	assign backlightOn = !st_q.dark;
	assign selInput = st_q.sel;
	assign autoSelect = st_q.ctrl[fp_pkg::CTRL_AUTO];
	assign convMode = st_q.conv;
	assign dynAddrEnable = st_q.dyn;
	assign restartReq = st_q.restart;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	property p_darkAllOff;
		@(posedge clock) disable iff (!rstn)
		st_q.dark && !pif.pressEdge && !knobEv |=> ledPower == fp_pkg::LED_OFF
			&& ledLink == fp_pkg::LED_OFF
			&& ledIn1 == fp_pkg::LED_OFF && ledLaser == fp_pkg::LED_OFF && !backlightOn;
	endproperty
	a_darkAllOff: assert property (p_darkAllOff) else $error("led lit in dark");

	property p_laserRed;
		@(posedge clock) disable iff (!rstn)
		normalView && st_q.cond[fp_pkg::COND_LASER] |=> ledLaser == fp_pkg::LED_RED;
	endproperty
	a_laserRed: assert property (p_laserRed) else $error("laser led not red");

	property p_linkGreen;
		@(posedge clock) disable iff (!rstn)
		normalView && st_q.bst == fp_pkg::B_IDLE && st_q.cond[fp_pkg::COND_LINK]
			&& !st_q.cond[fp_pkg::COND_LINKERR] |=> ledLink == fp_pkg::LED_GREEN;
	endproperty
	a_linkGreen: assert property (p_linkGreen) else $error("link led wrong");

	property p_convSplit;
		@(posedge clock) disable iff (!rstn)
		normalView && !isTx && st_q.bst == fp_pkg::B_IDLE
			&& st_q.conv == fp_pkg::CONV_SPLIT |=> ledConv == fp_pkg::LED_GREEN;
	endproperty
	a_convSplit: assert property (p_convSplit) else $error("conv led wrong");

	property p_toggle;
		@(posedge clock) disable iff (!rstn)
		shortPress && isTx |=> selInput != $past(selInput) && !autoSelect;
	endproperty
	a_toggle: assert property (p_toggle) else $error("select press ignored");

	property p_lockNoAction;
		@(posedge clock) disable iff (!rstn)
		st_q.bst == fp_pkg::B_LOCK |=> $stable(selInput) && $stable(convMode);
	endproperty
	a_lockNoAction: assert property (p_lockNoAction) else $error("locked press acted");

	property p_doneDyn;
		@(posedge clock) disable iff (!rstn)
		st_q.bst == fp_pkg::B_SEQ ##1 st_q.bst == fp_pkg::B_DONE |=> dynAddrEnable
			&& ledPower == fp_pkg::LED_OFF;
	endproperty
	a_doneDyn: assert property (p_doneDyn) else $error("sequence not accepted");

	property p_timeout;
		@(posedge clock) disable iff (!rstn)
		st_q.bst == fp_pkg::B_SEQ && !pif.pressEdge && pif.msTick
			&& st_q.msCnt == 16'(WINDOW_MS - 1) |=> st_q.bst == fp_pkg::B_IDLE
			&& $stable(dynAddrEnable);
	endproperty
	a_timeout: assert property (p_timeout) else $error("window not abandoned");

	c_shortPress: cover property (@(posedge clock) disable iff (!rstn) shortPress);
	c_lock: cover property (@(posedge clock) disable iff (!rstn) st_q.bst == fp_pkg::B_LOCK);
	c_done: cover property (@(posedge clock) disable iff (!rstn) st_q.restart);
	c_dark: cover property (@(posedge clock) disable iff (!rstn) st_q.dark);
endmodule

/* verilog/panel_if.sv */
// timebase and filtered button events shared by the panel modules
`timescale 1ns/1ps
interface panel_if;
	logic msTick;
	logic blink;
	logic pressEdge;
	logic releaseEdge;
	modport timebase(output msTick, output blink);
	modport filter(input msTick, output pressEdge, output releaseEdge);
	modport core(input msTick, input blink, input pressEdge, input releaseEdge);
endinterface

/* verilog/tick_gen.sv */
// millisecond tick and slow blink phase
`timescale 1ns/1ps
module tick_gen #(
	parameter int TICK_CYCLES = fp_pkg::TICK_CYCLES
) (
	// clock and reset
	input wire logic clock,
	input wire logic rstn,
	// timebase out
	panel_if.timebase pif
);
	fp_pkg::tick_st_t st_q;
	fp_pkg::tick_st_t st_d;

	// ----------------------------------------
	// prescaler
	// ----------------------------------------
	always_comb begin
		st_d = st_q;
		st_d.tick = 1'b0;
		if (st_q.cnt == 18'(TICK_CYCLES - 1)) begin
			st_d.cnt = '0;
			st_d.tick = 1'b1;
		end else begin
			st_d.cnt = st_q.cnt + 18'h1;
		end
		if (st_q.tick) begin
			if (st_q.bcnt == 8'(fp_pkg::BLINK_HALF_MS - 1)) begin
				st_d.bcnt = '0;
				st_d.blink = ~st_q.blink;
			end else begin
				st_d.bcnt = st_q.bcnt + 8'h1;
			end
		end
	end

	always_ff @(posedge clock) begin
		if (!rstn) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	assign pif.msTick = st_q.tick;
	assign pif.blink = st_q.blink;
endmodule
